// *** hw/scsd_pkg.sv ***
// constants and carrier types for the secondary configuration select decoder
package scsd_pkg;

  // ==========================================================================
  // primary address field positions
  localparam int DEV_NUM_MSB   = 15;
  localparam int DEV_NUM_LSB   = 11;
  localparam int FUNC_NUM_MSB  = 10;
  localparam int FUNC_NUM_LSB  = 8;
  localparam int REG_NUM_MSB   = 7;
  localparam int REG_NUM_LSB   = 2;

  // ==========================================================================
  // decode limits
  localparam logic [4:0] DEV_LAST_SELECTABLE = 5'h0f;
  localparam logic [4:0] DEV_SPECIAL         = 5'h1f;
  localparam int         IDSEL_WIDTH         = 16;
  localparam logic [15:0] IDSEL_NONE         = 16'h0000;
  localparam logic [15:0] IDSEL_ONE          = 16'h0001;

  // ==========================================================================
  // class codes and reset values
  localparam logic [23:0] CLASS_BRIDGE     = 24'h060400;  // standard pci-to-pci bridge
  localparam logic [23:0] CLASS_NONSTD     = 24'hff0000;  // unassigned class, hidden from enumeration
  localparam logic [23:0] CLASS_RESET      = 24'h060400;
  localparam logic        ARB_GRANT_RESET  = 1'b0;

  // ==========================================================================
  // link clock figures
  localparam int REVERSE_PCI_CLK_MHZ = 33;
  localparam int REF_CLK_MHZ         = 100;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [4:0] dev_num;
    logic [2:0] func_num;
    logic [5:0] reg_num;
  } scsd_cfg_req_type;

  typedef struct packed {
    logic [15:0] idsel;
    logic        special_cycle;
    logic        cfg_access;
  } scsd_cfg_res_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ISSUE = 2'b10
  } scsd_state_type;

endpackage

// *** hw/scsd_top.sv ***
// secondary-side configuration select decoder and reverse-mode pin roles
`timescale 1ns/1ns

// Functional notes
// - device 0h..Fh drives exactly one select line, bit 16 plus device number
// - device 1Fh with nonzero register field issues a special cycle
// - device 1Fh with zero register field: no special cycle, no select
// - reverse mode: own select comes from host controller on select pin
// - reverse mode: feedback clock at 33MHz clocks pci; primary and outputs unused
// - reverse mode: request pin zero is grant in, grant pin zero is request out
// - non-transparent mode reports a nonstandard class code
// - serial link reference clocks may be asynchronous if partner supports it
// - forward mode: own select pin tied low; devices take select from lines 16..31
module scsd_top (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // configuration request from the upstream path
  input  wire logic                       cfg_req_valid,
  input  wire logic [31:0]                cfg_addr,
  output logic                            cfg_req_ready,
  // converted secondary request
  output scsd_pkg::scsd_cfg_res_type      cfg_res,
  output logic                            cfg_res_valid,
  // mode straps and pins from outside
  input  wire logic                       reverse_mode_pin,
  input  wire logic                       nontransparent_pin,
  input  wire logic                       cfg_select_pin,
  input  wire logic                       partner_async_clk_pin,
  input  wire logic                       arb_request_pin_zero,
  input  wire logic                       bus_need,
  // derived pin roles and status
  output logic                            arb_grant_pin_zero,
  output logic                            bus_granted,
  output logic                            self_cfg_select,
  output logic                            use_feedback_clock_in,
  output logic                            secondary_clock_out_en,
  output logic                            refclk_async_ok,
  output logic [23:0]                     class_code
);

  // ==========================================================================
  // pin synchronisers: two stages, first stage read only by the second
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] pin_raw;
  logic             reverse_mode;
  logic             nontransparent;
  logic             cfg_select;
  logic             partner_async;
  logic             arb_req_in;

  assign pin_raw = {reverse_mode_pin, nontransparent_pin, cfg_select_pin,
                    partner_async_clk_pin, arb_request_pin_zero};

  // plain two-flop chain per pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  assign reverse_mode   = sync_b[4];
  assign nontransparent = sync_b[3];
  assign cfg_select     = sync_b[2];
  assign partner_async  = sync_b[1];
  assign arb_req_in     = sync_b[0];

  // ==========================================================================
  // request decode
  scsd_pkg::scsd_cfg_req_type req;
  scsd_pkg::scsd_cfg_res_type decoded;

  assign req.dev_num  = cfg_addr[scsd_pkg::DEV_NUM_MSB:scsd_pkg::DEV_NUM_LSB];
  assign req.func_num = cfg_addr[scsd_pkg::FUNC_NUM_MSB:scsd_pkg::FUNC_NUM_LSB];
  assign req.reg_num  = cfg_addr[scsd_pkg::REG_NUM_MSB:scsd_pkg::REG_NUM_LSB];

  // one-hot select table; all-zero for high device numbers
  always_comb begin
    decoded.idsel         = scsd_pkg::IDSEL_NONE;
    decoded.special_cycle = 1'b0;
    decoded.cfg_access    = 1'b0;
    if (req.dev_num <= scsd_pkg::DEV_LAST_SELECTABLE) begin
      decoded.idsel      = scsd_pkg::IDSEL_ONE << req.dev_num[3:0];
      decoded.cfg_access = 1'b1;
    end else if (req.dev_num == scsd_pkg::DEV_SPECIAL) begin
      decoded.special_cycle = (req.reg_num != 6'h00);
    end else begin
      decoded.cfg_access = 1'b1;  // access runs but selects nobody
    end
  end

  // ==========================================================================
  // issue state machine: one request in flight, result held one cycle
  scsd_pkg::scsd_state_type   state;
  scsd_pkg::scsd_state_type   next_state;
  scsd_pkg::scsd_cfg_res_type next_res;

  always_comb begin
    next_state = state;
    next_res   = '0;
    case (state)
      scsd_pkg::ST_IDLE: begin
        if (cfg_req_valid) begin
          next_state = scsd_pkg::ST_ISSUE;
          next_res   = decoded;
        end
      end
      scsd_pkg::ST_ISSUE: begin
        next_state = scsd_pkg::ST_IDLE;  // lines drop back low after one cycle
      end
      default: begin
        next_state = scsd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state   <= scsd_pkg::ST_IDLE;
      cfg_res <= '0;
    end else begin
      state   <= next_state;
      cfg_res <= next_res;
    end
  end

  assign cfg_req_ready = (state == scsd_pkg::ST_IDLE);
  assign cfg_res_valid = (state == scsd_pkg::ST_ISSUE);

  // ==========================================================================
  // pin roles per mode
  logic        next_grant;
  logic        next_self_sel;
  logic [23:0] next_class;

  // forward: grant follows the lone requester; reverse: pin carries our request
  always_comb begin
    next_grant    = reverse_mode ? bus_need : arb_req_in;
    next_self_sel = reverse_mode ? cfg_select : 1'b0;
    next_class    = nontransparent ? scsd_pkg::CLASS_NONSTD
                                   : scsd_pkg::CLASS_BRIDGE;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arb_grant_pin_zero <= scsd_pkg::ARB_GRANT_RESET;
      self_cfg_select    <= 1'b0;
      class_code         <= scsd_pkg::CLASS_RESET;
    end else begin
      arb_grant_pin_zero <= next_grant;
      self_cfg_select    <= next_self_sel;
      class_code         <= next_class;
    end
  end

  // in reverse mode the request pin is the host arbiter's grant to us
  assign bus_granted = reverse_mode & arb_req_in;

  // clock source select only; the actual mux sits in the clocking block
  assign use_feedback_clock_in  = reverse_mode;
  assign secondary_clock_out_en = ~reverse_mode;
  // async reference clocking only when the partner claims support
  assign refclk_async_ok = partner_async;

  // ==========================================================================
  // assertions
  sequence s_take_low_dev;
    cfg_req_ready && cfg_req_valid && req.dev_num <= 5'h0f;
  endsequence

  sequence s_take_special;
    cfg_req_ready && cfg_req_valid && req.dev_num == 5'h1f && req.reg_num != 6'h00;
  endsequence

  a_low_dev_onehot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_take_low_dev |=> cfg_res_valid && $onehot(cfg_res.idsel)
      && cfg_res.idsel == (16'h0001 << $past(cfg_addr[14:11])))
    else $error("select line does not match device number");

  a_high_dev_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_req_ready && cfg_req_valid && req.dev_num >= 5'h10 && req.dev_num <= 5'h1e
      |=> cfg_res.idsel == 16'h0000 && !cfg_res.special_cycle)
    else $error("high device number selected a line");

  a_special_issue: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_take_special |=> cfg_res.special_cycle && !cfg_res.cfg_access ##1 !cfg_res.special_cycle)
    else $error("special cycle not issued for one cycle");

  a_special_zero_reg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_req_ready && cfg_req_valid && req.dev_num == 5'h1f && req.reg_num == 6'h00
      |=> !cfg_res.special_cycle && cfg_res.idsel == 16'h0000)
    else $error("special cycle issued with zero register field");

  a_self_select_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 self_cfg_select == ($past(reverse_mode) && $past(cfg_select)))
    else $error("own select does not follow mode and pin");

  a_clock_roles: assert property (@(posedge clk_sys) disable iff (!rst_n)
    use_feedback_clock_in != secondary_clock_out_en)
    else $error("clock outputs enabled while on feedback clock");

  a_reverse_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reverse_mode && $stable(reverse_mode) |=> arb_grant_pin_zero == $past(bus_need))
    else $error("grant pin does not carry bus request in reverse mode");

  a_class_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nontransparent |=> class_code != 24'h060400)
    else $error("standard class reported in non-transparent mode");

  a_idle_lines_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_res_valid |-> cfg_res.idsel == 16'h0000 && !cfg_res.special_cycle)
    else $error("select lines driven outside an issue cycle");

endmodule

// *** testbench/scsd_host_model.sv ***
// host-side controller model: arbiter for the pin-zero pair and select driver
`timescale 1ns/1ns
module scsd_host_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // bridge request and bench controls
  input  wire logic bus_req,
  input  wire logic slow,
  input  wire logic addr_me,
  // toward the bridge
  output logic      host_grant,
  output logic      host_idsel
);
  logic [2:0] wait_cnt;

  // ==========================================================================
  // arbiter: grant after a short or long wait, drop with the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt   <= 3'h0;
      host_grant <= 1'b0;
    end else if (!bus_req) begin
      wait_cnt   <= 3'h0;
      host_grant <= 1'b0;
    end else if (slow && wait_cnt < 3'h3) begin
      wait_cnt   <= wait_cnt + 3'h1;
    end else begin
      host_grant <= 1'b1;
    end
  end

  // select drives the bridge only while the host addresses it
  assign host_idsel = addr_me;
endmodule

// *** testbench/secondary_config_select_decode_tb.sv ***
// self-checking bench for the secondary configuration select decoder
`timescale 1ns/1ns
module secondary_config_select_decode_tb;
  logic        clk_sys = 0, rst_n = 0, cfg_req_valid = 0, rev = 0, ntb = 0;
  logic        async_pin = 0, bus_need = 0, slow = 0, addr_me = 0;
  logic        host_grant, host_idsel, cfg_req_ready, cfg_res_valid, arb_gnt, granted;
  logic        self_sel, use_fb, clk_out_en, async_ok;
  logic [31:0] cfg_addr = 32'h0;
  logic [23:0] class_code;
  scsd_pkg::scsd_cfg_res_type cfg_res;
  int          fail_count = 0, check_count = 0, i;

  always #10 clk_sys = ~clk_sys;

  scsd_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req_valid(cfg_req_valid), .cfg_addr(cfg_addr),
    .cfg_req_ready(cfg_req_ready), .cfg_res(cfg_res), .cfg_res_valid(cfg_res_valid),
    .reverse_mode_pin(rev), .nontransparent_pin(ntb), .cfg_select_pin(host_idsel),
    .partner_async_clk_pin(async_pin), .arb_request_pin_zero(host_grant), .bus_need(bus_need),
    .arb_grant_pin_zero(arb_gnt), .bus_granted(granted), .self_cfg_select(self_sel),
    .use_feedback_clock_in(use_fb), .secondary_clock_out_en(clk_out_en),
    .refclk_async_ok(async_ok), .class_code(class_code));

  scsd_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(arb_gnt), .slow(slow),
    .addr_me(addr_me), .host_grant(host_grant), .host_idsel(host_idsel));

  // ==========================================================================
  // expectation and comparison
  function automatic scsd_pkg::scsd_cfg_res_type exp_res(input logic [31:0] a);
    scsd_pkg::scsd_cfg_res_type r;
    r = '0;
    if (a[15:11] <= 5'h0f) begin
      r.idsel      = 16'h0001 << a[15:11];
      r.cfg_access = 1'b1;
    end else if (a[15:11] != 5'h1f) r.cfg_access = 1'b1;
    else if (a[7:2] != 6'h00) r.special_cycle = 1'b1;
    return r;
  endfunction

  task automatic chk_res(input scsd_pkg::scsd_cfg_res_type e, input scsd_pkg::scsd_cfg_res_type g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value cfg_res expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // one request: hold until taken, then check the one-cycle answer
  task automatic issue(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    cfg_req_valid <= 1'b1;
    cfg_addr      <= a;
    @(negedge clk_sys);
    while (cfg_req_ready !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    chk_val("req_ready", 24'h1, {23'h0, cfg_req_ready});
    @(posedge clk_sys);
    cfg_req_valid <= 1'b0;
    cfg_addr      <= ~a;  // released lines show no stale value
    @(negedge clk_sys);
    chk_val("res_valid", 24'h1, {23'h0, cfg_res_valid});
    chk_val("req_ready", 24'h0, {23'h0, cfg_req_ready});
    chk_res(exp_res(a), cfg_res);
    @(negedge clk_sys);
    chk_val("res_valid", 24'h0, {23'h0, cfg_res_valid});
    chk_res('0, cfg_res);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(55));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(1);
    chk_val("class", 24'h060400, class_code);
    chk_val("clk_out_en", 24'h1, {23'h0, clk_out_en});
    for (i = 0; i < 32; i++) issue({16'h0, i[4:0], 11'h0});
    issue(32'h0000f804);
    issue(32'h0000fffc);
    issue(32'h0000ff03);
    repeat (40) issue($urandom);
    @(posedge clk_sys);
    async_pin <= 1'b1;
    addr_me   <= 1'b1;
    settle(5);
    chk_val("async_ok", 24'h1, {23'h0, async_ok});
    chk_val("self_sel", 24'h0, {23'h0, self_sel});
    @(posedge clk_sys);
    ntb <= 1'b1;
    settle(5);
    chk_val("class", 24'hff0000, class_code);
    @(posedge clk_sys);
    rev  <= 1'b1;
    slow <= 1'b1;
    settle(5);
    chk_val("use_fb", 24'h1, {23'h0, use_fb});
    chk_val("clk_out_en", 24'h0, {23'h0, clk_out_en});
    chk_val("self_sel", 24'h1, {23'h0, self_sel});
    @(posedge clk_sys);
    bus_need <= 1'b1;
    settle(2);
    chk_val("arb_gnt", 24'h1, {23'h0, arb_gnt});
    settle(10);
    chk_val("granted", 24'h1, {23'h0, granted});
    @(posedge clk_sys);
    bus_need <= 1'b0;
    settle(8);
    chk_val("granted", 24'h0, {23'h0, granted});
    // fast host arbiter: grant without the wait states
    @(posedge clk_sys);
    slow     <= 1'b0;
    bus_need <= 1'b1;
    settle(6);
    chk_val("granted", 24'h1, {23'h0, granted});
    @(posedge clk_sys);
    bus_need <= 1'b0;
    settle(8);
    chk_val("granted", 24'h0, {23'h0, granted});
    issue(32'h00002800);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    settle(1);
    chk_val("class", 24'h060400, class_code);
    stop_test();
  end
endmodule
